// file: common/port_upper_pkg.sv
// constants and carrier types for the upper port pin-sharing block
// assumes a single cpu clock domain; no bus, all bits are plain ports
package port_upper_pkg;
    // port bit positions
    localparam int BIT_B_RX = 4;
    localparam int BIT_A_RX = 5;
    localparam int BIT_A_TX = 6;
    localparam int BIT_B_TX = 7;
    localparam int PORT_W = 8;
    // segment address lines available with no can unit and with any can unit in use
    localparam int SEG_LINES_ALL = 8;
    localparam int SEG_LINES_CAN = 4;
    // external memory in mbytes with a reduced segment count
    localparam int MEM_MBYTES_CAN = 5;
    // message objects per unit, and combined on one bus
    localparam int MSG_OBJ_UNIT = 32;
    localparam int MSG_OBJ_SHARED = 64;
    // can unit selected by address bit 8
    localparam int CAN_SEL_BIT = 8;
    // reset values of the unit enables: unit a on, unit b off
    localparam logic CAN_A_EN_RST = 1'b1;
    localparam logic CAN_B_EN_RST = 1'b0;
    // extended-bus interrupt vectors shared with other peripherals
    localparam int XB_VECTORS = 4;
    localparam int XB_IRQ_A = 0;
    localparam int XB_IRQ_B = 1;

    // software-written configuration bits
    typedef struct packed {
        logic can_a_unit_enable;
        logic can_b_unit_enable;
        logic two_wire_enable;
        logic misc_reg_access_enable;
        logic ext_periph_global_enable;
        logic can_parallel_map;
    } cfg_s;

    // one can unit's pin-facing signals
    typedef struct packed {
        logic tx;
        logic irq;
    } can_side_s;

    // two-wire interface pin and interrupt signals
    typedef struct packed {
        logic scl_oe;
        logic sda_oe;
        logic irq_event;
        logic irq_tx;
        logic irq_rx;
    } tw_side_s;
endpackage

// file: core/pin_sync.sv
// two-flop synchroniser bank for pin inputs
// assumes asynchronous pins; output is safe for logic on clock
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // async input and synchronised output
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // first stage, read only by the second stage
    logic [W-1:0] meta_r;

    // both stages reset high, the idle level of pulled-up pins, so a
    // routed receive line shows no false dominant bit after reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '1;
            sync_out <= '1;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// file: core/port_upper_mux.sv
// pin sharing for the upper port: two can units and the two-wire unit
// assumes the can and two-wire engines and port registers are outside
`timescale 1ns/10ps
// How it works
// - unit a tx bit 6, rx bit 5
// - unit b tx bit 7, rx bit 4
// - same offsets, units picked by address bit 8
// - reset: unit a enabled, unit b disabled
// - can in use limits segment lines to four
// - per-pin open-drain on can transmit pins
// - shared bus gives sixty-four message objects
// - parallel map puts both units on 5,6
// - two-wire enable makes 4,7 open-drain bus
// - two-wire off: 4 follows port registers, 7 too unless unit b owns it
// - two-wire drives three separate interrupt lines
// - can interrupts go to extended-bus lines
module port_upper_mux
    import port_upper_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // software configuration
    input wire port_upper_pkg::cfg_s cfg,
    input wire logic cfg_load,
    // port registers
    input wire logic [7:0] port_upper_data_reg,
    input wire logic [7:0] port_upper_direction_reg,
    input wire logic [7:0] port_upper_open_drain_reg,
    // can units
    input wire port_upper_pkg::can_side_s can_a,
    input wire port_upper_pkg::can_side_s can_b,
    input wire logic [15:0] can_addr,
    input wire logic can_cs_req,
    output logic can_a_cs,
    output logic can_b_cs,
    output logic can_a_rx,
    output logic can_b_rx,
    // two-wire unit
    input wire port_upper_pkg::tw_side_s tw,
    output logic tw_scl_in,
    output logic tw_sda_in,
    // interrupt lines
    output logic [3:0] xbus_irq,
    output logic tw_irq_event,
    output logic tw_irq_tx,
    output logic tw_irq_rx,
    // status
    output logic [3:0] seg_lines_max,
    output logic [6:0] msg_obj_total,
    output logic can_a_active,
    output logic can_b_active,
    output logic tw_active,
    output logic misc_access_ok,
    // pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    // port readback
    output logic [7:0] port_read
);
    // synchronised pin levels
    logic [7:0] pin_s;
    // held configuration
    logic en_a_r;
    logic en_b_r;
    logic tw_en_r;
    logic par_r;
    logic glb_r;
    logic misc_r;
    // registered outputs
    logic [7:0] out_r;
    logic [7:0] oe_r;
    logic rx_a_r;
    logic rx_b_r;
    logic scl_r;
    logic sda_r;

    pin_sync #(.W(PORT_W)) pin_sync_inst (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(pin_in),
        .sync_out(pin_s)
    );

    // configuration register; parallel map only writable when unlocked
    // reset enables
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_a_r <= CAN_A_EN_RST;
            en_b_r <= CAN_B_EN_RST;
            tw_en_r <= 1'b0;
            par_r <= 1'b0;
            glb_r <= 1'b0;
            misc_r <= 1'b0;
        end else if (cfg_load) begin
            en_a_r <= cfg.can_a_unit_enable;
            en_b_r <= cfg.can_b_unit_enable;
            tw_en_r <= cfg.two_wire_enable;
            glb_r <= cfg.ext_periph_global_enable;
            misc_r <= cfg.misc_reg_access_enable;
            // misc register gated by both enables
            if (misc_r && glb_r) begin
                par_r <= cfg.can_parallel_map;
            end
        end
    end

    a_rst_enables: assert property (
        @(posedge clock) !rst_n |=> (en_a_r && !en_b_r && !glb_r))
        else $error("reset enables wrong");

    // unit is live only with its enable and the global enable
    // global enable qualifies unit enable
    wire a_live = en_a_r && glb_r;
    wire b_live = en_b_r && glb_r;
    wire par_live = par_r && (a_live || b_live);
    // two-wire owns bits 4 and 7 over can unit b
    wire tw_live = tw_en_r && glb_r;
    wire b_pins = b_live && !par_live && !tw_live;

    // address bit 8 picks the unit, offsets identical
    assign can_a_cs = can_cs_req && a_live && !can_addr[CAN_SEL_BIT];
    assign can_b_cs = can_cs_req && b_live && can_addr[CAN_SEL_BIT];

    wire tx6 = par_live ? ((a_live ? can_a.tx : 1'b1) &
                           (b_live ? can_b.tx : 1'b1)) : can_a.tx;

    // per-bit pin drive decision
    function automatic logic [1:0] gpio_drive(input logic d,
                                              input logic dir,
                                              input logic od);
        // returns {oe, out}; open drain drives only the low level
        gpio_drive = od ? {dir && !d, 1'b0} : {dir, d};
    endfunction

    function automatic logic [1:0] tx_drive(input logic t, input logic od);
        tx_drive = od ? {!t, 1'b0} : {1'b1, t};
    endfunction

    logic [1:0] drv [PORT_W];
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_bit
            if (gi == BIT_A_TX) begin : g_a
                // unit a transmit on bit 6
                // both units on bit 6 in parallel mode
                assign drv[gi] = (a_live || par_live) ?
                    tx_drive(tx6, port_upper_open_drain_reg[gi]) :
                    gpio_drive(port_upper_data_reg[gi],
                               port_upper_direction_reg[gi],
                               port_upper_open_drain_reg[gi]);
            end else if (gi == BIT_B_TX) begin : g_b
                // unit b transmit on bit 7
                // fall back to port when unclaimed
                assign drv[gi] = tw_live ? {tw.sda_oe, 1'b0} :
                    b_pins ? tx_drive(can_b.tx,
                                      port_upper_open_drain_reg[gi]) :
                    gpio_drive(port_upper_data_reg[gi],
                               port_upper_direction_reg[gi],
                               port_upper_open_drain_reg[gi]);
            end else if (gi == BIT_B_RX) begin : g_c
                // port registers rule when two-wire off
                assign drv[gi] = tw_live ? {tw.scl_oe, 1'b0} :
                    gpio_drive(port_upper_data_reg[gi],
                               port_upper_direction_reg[gi],
                               port_upper_open_drain_reg[gi]);
            end else begin : g_p
                assign drv[gi] = gpio_drive(port_upper_data_reg[gi],
                                            port_upper_direction_reg[gi],
                                            port_upper_open_drain_reg[gi]);
            end
        end
    endgenerate

    logic [7:0] oe_nxt;
    logic [7:0] out_nxt;
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            oe_nxt[i] = drv[i][1];
            out_nxt[i] = drv[i][0];
        end
    end

    // receive routing
    // unit a receive from bit 5
    // bit 5 feeds both units in parallel
    wire rx_b_nxt = par_live ? pin_s[BIT_A_RX] :
                    b_pins ? pin_s[BIT_B_RX] : 1'b1;
    wire rx_a_nxt = (a_live || par_live) ? pin_s[BIT_A_RX] : 1'b1;

    // registered pin drive and routed inputs; recessive when idle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= 8'h00;
            oe_r <= 8'h00;
            rx_a_r <= 1'b1;
            rx_b_r <= 1'b1;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            rx_a_r <= rx_a_nxt;
            // unit b receive from bit 4
            rx_b_r <= rx_b_nxt;
            scl_r <= tw_live ? pin_s[BIT_B_RX] : 1'b1;
            sda_r <= tw_live ? pin_s[BIT_B_TX] : 1'b1;
        end
    end

    assign pin_out = out_r;
    assign pin_oe = oe_r;
    assign can_a_rx = rx_a_r;
    assign can_b_rx = rx_b_r;
    assign tw_scl_in = scl_r;
    assign tw_sda_in = sda_r;
    assign port_read = pin_s;

    assign tw_irq_event = tw_live && tw.irq_event;
    assign tw_irq_tx = tw_live && tw.irq_tx;
    assign tw_irq_rx = tw_live && tw.irq_rx;

    // can interrupts onto shared extended-bus lines
    assign xbus_irq = {2'b00, b_live && can_b.irq, a_live && can_a.irq};

    // four segment lines with any can unit active
    assign seg_lines_max = (a_live || b_live) ? 4'(SEG_LINES_CAN) :
                                                4'(SEG_LINES_ALL);
    assign msg_obj_total = (a_live && b_live) ? 7'(MSG_OBJ_SHARED) :
                           (a_live || b_live) ? 7'(MSG_OBJ_UNIT) : 7'h00;

    assign can_a_active = a_live;
    assign can_b_active = b_live;
    assign tw_active = tw_live;
    assign misc_access_ok = misc_r && glb_r;

    // checks
    // clock pin pulls low only
    a_tw_owns_clk: assert property (
        @(posedge clock) disable iff (!rst_n)
        tw_live |=> (pin_out[BIT_B_RX] == 1'b0))
        else $error("two-wire clock pin drove high");
    a_tw_off_gpio: assert property (
        @(posedge clock) disable iff (!rst_n)
        (!tw_live && !b_pins) |=> pin_oe[BIT_B_TX] ==
        $past(port_upper_direction_reg[BIT_B_TX] &&
        !(port_upper_open_drain_reg[BIT_B_TX] &&
        port_upper_data_reg[BIT_B_TX])))
        else $error("bit 7 not following port registers");
    a_seg_limit: assert property (
        @(posedge clock) disable iff (!rst_n)
        (a_live || b_live) |-> seg_lines_max == 4'd4)
        else $error("segment limit missing");
    a_sel_bit8: assert property (
        @(posedge clock) disable iff (!rst_n)
        !(can_a_cs && can_b_cs))
        else $error("both can units selected");
    a_par_wand: assert property (
        @(posedge clock) disable iff (!rst_n)
        (par_live && b_live && !can_b.tx)
        |=> (pin_oe[BIT_A_TX] && !pin_out[BIT_A_TX]))
        else $error("parallel tx not wired-and");
    a_od_tx: assert property (
        @(posedge clock) disable iff (!rst_n)
        (a_live && !par_live && port_upper_open_drain_reg[BIT_A_TX] &&
        can_a.tx) |=> (!pin_oe[BIT_A_TX] && !pin_out[BIT_A_TX]))
        else $error("open-drain tx drove high");
    a_rx_route: assert property (
        @(posedge clock) disable iff (!rst_n)
        $past(a_live) |-> can_a_rx == $past(pin_in[BIT_A_RX], 3))
        else $error("unit a receive misrouted");
    a_irq_tw: assert property (
        @(posedge clock) disable iff (!rst_n)
        tw_live |-> (tw_irq_rx == tw.irq_rx &&
        tw_irq_tx == tw.irq_tx))
        else $error("two-wire interrupt lines merged");
    a_msg_obj: assert property (
        @(posedge clock) disable iff (!rst_n)
        (a_live && b_live) |-> msg_obj_total == 7'd64)
        else $error("shared message count wrong");
    c_parallel: cover property (@(posedge clock) par_live);
    c_two_wire: cover property (@(posedge clock) tw_live && a_live);
    c_both_can: cover property (@(posedge clock) b_pins && a_live);
endmodule

// file: sim/bus_partner.sv
// far side of the upper port: can transceiver and two-wire devices
// assumes pull-ups on every pin; the bench pulls lines low via ext_low
`timescale 1ns/10ps
module bus_partner (
    // pins as driven by the design
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // outside devices pulling the wire low
    input wire logic [7:0] ext_low,
    // resolved wire level fed back to the design
    output logic [7:0] pin_in
);
    // wired-and with pull-up
    // a released line goes to the pull-up, never holds its last value
    assign pin_in = ~(pin_oe & ~pin_out) & ~ext_low;
endmodule

// file: sim/tb_port_upper_mux.sv
// self-checking bench for the upper port pin-sharing block
// assumes bus_partner closes the pin loop with pull-ups
`timescale 1ns/10ps
module tb_port_upper_mux;
    import port_upper_pkg::*;
    // clock, reset and design inputs
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    cfg_s cfg = '0;
    logic cfg_load = 1'b0;
    logic [7:0] dat = 8'h00, dir = 8'h00, od = 8'h00, ext = 8'h00;
    can_side_s ca = '0, cb = '0;
    tw_side_s tw = '0;
    logic [15:0] addr = 16'h0000;
    logic cs_req = 1'b0;
    // design outputs
    logic a_cs, b_cs, a_rx, b_rx, scl, sda, ev, ti, ri;
    logic a_act, b_act, t_act, m_ok;
    logic [3:0] xirq, seg;
    logic [6:0] msg;
    logic [7:0] pin_in, pin_out, pin_oe;
    logic [7:0] rd;
    // observed words: 0 pins, 1 receive/irq/select, 2 status, 3 readback
    wire [15:0] o_pin = {pin_oe, pin_out};
    wire [15:0] o_rx = {a_rx, b_rx, scl, sda, xirq, ev, ti, ri, a_cs, b_cs,
                        3'h0};
    wire [15:0] o_st = {a_act, b_act, t_act, m_ok, seg, 1'b0, msg};
    wire [15:0] o_rd = {8'h00, rd};
    wire [63:0] obs_all = {o_rd, o_st, o_rx, o_pin};
    // notes: word select, mask, expected value
    logic [47:0] q [$];
    event seen;
    int err_total = 0;
    int checks = 0;

    always #4 clock = ~clock;

    port_upper_mux port_upper_mux_inst (
        .clock(clock), .rst_n(rst_n), .cfg(cfg), .cfg_load(cfg_load),
        .port_upper_data_reg(dat), .port_upper_direction_reg(dir),
        .port_upper_open_drain_reg(od), .can_a(ca), .can_b(cb),
        .can_addr(addr), .can_cs_req(cs_req), .can_a_cs(a_cs),
        .can_b_cs(b_cs), .can_a_rx(a_rx), .can_b_rx(b_rx), .tw(tw),
        .tw_scl_in(scl), .tw_sda_in(sda), .xbus_irq(xirq),
        .tw_irq_event(ev), .tw_irq_tx(ti), .tw_irq_rx(ri),
        .seg_lines_max(seg), .msg_obj_total(msg), .can_a_active(a_act),
        .can_b_active(b_act), .tw_active(t_act), .misc_access_ok(m_ok),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .port_read(rd));

    bus_partner bus_partner_inst (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_low(ext), .pin_in(pin_in));

    // one comparison, counted; unknowns never match
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // verdict and end of run, shared with the watchdog
    task automatic results();
        $display("checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // driver side: note the expectation where outputs are settled,
    // then hand back on a rising edge so stimulus lands on that edge
    task automatic note(input int s, input logic [15:0] m,
                        input logic [15:0] e);
        @(negedge clock);
        q.push_back({16'(s), m, e});
        -> seen;
        @(posedge clock);
    endtask

    // watcher side: oldest note against what the outputs show
    always @(seen) begin
        logic [47:0] n;
        n = q.pop_front();
        cmp(obs_all[int'(n[47:32]) * 16 +: 16] & n[31:16], n[15:0]);
    end

    // bits a, b, two-wire, misc, global, parallel from msb down
    function automatic cfg_s mk(input logic [5:0] v);
        return cfg_s'(v);
    endfunction

    // stimulus sets unit enables in a load before the global enable, except the two-wire case, which sets both in one load
    // leaves room for pins (1 edge) and receive (3 edges) to follow
    task automatic load(input cfg_s c);
        @(posedge clock);
        cfg <= c;
        cfg_load <= 1'b1;
        @(posedge clock);
        cfg_load <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    task automatic settle();
        repeat (6) @(posedge clock);
    endtask

    // watchdog: whole run is about 150 cycles
    initial begin
        #50000;
        err_total++;
        results();
    end

    initial begin
        int unsigned r;
        logic [7:0] d;
        r = $urandom(32'h5eb8);
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        // nothing live before any load
        note(2, 16'hffff, {4'h0, 4'(SEG_LINES_ALL), 8'h00});
        note(0, 16'hffff, 16'h0000);
        note(1, 16'hf000, 16'hf000);
        note(3, 16'h00ff, 16'h00ff);
        // both units on their own pins, open-drain transmit
        od <= 8'hc0;
        ca <= 2'b01;
        cb <= 2'b11;
        tw <= 5'b00111;
        ext <= 8'h20;
        load(mk(6'b110000));
        load(mk(6'b110010));
        note(2, 16'hffff, {4'hc, 4'(SEG_LINES_CAN), 1'b0,
                           7'(MSG_OBJ_SHARED)});
        note(0, 16'hffff, 16'h4000);
        note(1, 16'hffe0, {4'b0111, 4'b0011, 8'h00});
        ca <= 2'b10;
        cb <= 2'b01;
        ext <= 8'h10;
        settle();
        note(0, 16'hffff, 16'h8000);
        note(1, 16'hff00, {4'b1011, 4'b0010, 8'h00});
        // chip select follows address bit 8
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            r = $urandom;
            addr <= r[15:0];
            cs_req <= 1'b1;
            note(1, 16'h0018, {11'h0, ~r[8], r[8], 3'h0});
        end
        // plain port: push-pull, then open-drain
        ext <= 8'h00;
        d = 8'($urandom);
        dat <= d;
        dir <= 8'hff;
        od <= 8'h00;
        load(mk(6'b100000));
        note(0, 16'hffff, {8'hff, d});
        note(2, 16'hffff, {4'h0, 4'(SEG_LINES_ALL), 8'h00});
        note(3, 16'h00ff, {8'h00, d});
        od <= 8'hff;
        settle();
        note(0, 16'hffff, {~d, 8'h00});
        note(3, 16'h00ff, {8'h00, d});
        // two-wire owns bits 4 and 7 whatever the port registers say
        dat <= 8'h00;
        od <= 8'h40;
        // bit 5 stays an input so unit a keeps listening
        dir <= 8'hdf;
        ca <= 2'b11;
        cb <= 2'b11;
        tw <= 5'b10111;
        load(mk(6'b101010));
        note(2, 16'hffff, {4'ha, 4'(SEG_LINES_CAN), 1'b0,
                           7'(MSG_OBJ_UNIT)});
        note(0, 16'hffff, 16'h1f00);
        note(1, 16'hffe0, {4'b1101, 4'b0001, 3'b111, 5'h0});
        tw <= 5'b01000;
        settle();
        note(0, 16'hffff, 16'h8f00);
        note(1, 16'hffe0, {4'b1110, 4'b0001, 8'h00});
        // parallel map refused without the misc access enable
        dir <= 8'h00;
        od <= 8'hc0;
        ca <= 2'b10;
        cb <= 2'b00;
        tw <= 5'b00000;
        load(mk(6'b110000));
        load(mk(6'b110011));
        note(0, 16'hffff, 16'h8000);
        load(mk(6'b110110));
        load(mk(6'b110111));
        note(2, 16'hffff, {4'hd, 4'(SEG_LINES_CAN), 1'b0,
                           7'(MSG_OBJ_SHARED)});
        note(0, 16'hffff, 16'h4000);
        ext <= 8'h20;
        settle();
        note(1, 16'hc000, 16'h0000);
        ext <= 8'h10;
        ca <= 2'b10;
        cb <= 2'b10;
        settle();
        note(1, 16'hc000, 16'hc000);
        note(0, 16'hffff, 16'h0000);
        repeat (2) @(posedge clock);
        results();
    end
endmodule
